// ### rtl/burst_sram_port.sv
/*
 * Pipelined burst SRAM port: address/control registered on one edge, data on the next.
 * Assumes a synchronous partner on CLK_SYS; the data bus is split into in/out/enable.
 */
`timescale 1ns/100ps
`include "sram_port_defs.svh"

// Operation
// - a load with advance low ends any burst in progress
// - read-write is ignored while advancing a burst
// - burst direction is fixed by read-write captured at load
// - read-write low on a selected load starts a write
// - lane selects go with address cycle; data follows next cycle
// - clock enable high freezes burst, pipeline and memory state; synchronisers and output registers keep clocking
// - any chip select inactive at load starts a deselect, no operation
// - data bus goes high impedance one cycle after deselect
// - deselect still completes the data phase loaded one cycle earlier
// - selected only when both low selects low and high select high
// - write data is stored in the next cycle even if deselected then
// - data outputs stay high impedance until a read drives them
// - burst advances only the two lowest address bits
// - an undriven burst order input counts as interleaved
// - interleaved order: start address xor step count, wrapping
// - linear order: low bits plus one modulo four, wrapping
// - read loaded at n drives its word at n+1 with output enable low
// - four active-low lane selects each gate one nine-bit lane
module burst_sram_port #(
	parameter int ADDR_W = `ADDR_BITS,
	parameter int LANES = `LANES,
	parameter int LANE_W = `LANE_BITS
) (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic CLOCK_ENABLE_N,
	input wire logic ADVANCE_OR_LOAD,
	input wire logic READ_WRITE_N,
	input wire logic SELECT_LOW_A_N,
	input wire logic SELECT_LOW_B_N,
	input wire logic SELECT_HIGH,
	input wire logic BURST_ORDER_SEL,
	input wire logic BURST_ORDER_DRIVEN,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic [ADDR_W-1:0] ADDR,
	input wire logic [LANES-1:0] BYTE_LANE_WRITE_N,
	input wire logic [LANES*LANE_W-1:0] DATA_IN,
	output logic [LANES*LANE_W-1:0] DATA_OUT,
	output logic [LANES*LANE_W-1:0] DATA_OE
);
	localparam int DW = LANES * LANE_W;
	localparam int DEPTH = 1 << ADDR_W;

	// pin synchronisers: two flops before any logic
	logic [ADDR_W+LANES+DW+7:0] sync1, sync2;
	logic oe_s1, oe_s2;
	always_ff @(posedge CLK_SYS) begin
		sync1 <= {ADDR, BYTE_LANE_WRITE_N, DATA_IN, CLOCK_ENABLE_N, ADVANCE_OR_LOAD,
			READ_WRITE_N, SELECT_LOW_A_N, SELECT_LOW_B_N, SELECT_HIGH, BURST_ORDER_SEL,
			BURST_ORDER_DRIVEN};
		sync2 <= sync1;
		oe_s1 <= OUTPUT_ENABLE_N;
		oe_s2 <= oe_s1;
	end

	wire [ADDR_W-1:0] s_addr = sync2[ADDR_W+LANES+DW+7:LANES+DW+8];
	wire [LANES-1:0] s_lane_n = sync2[LANES+DW+7:DW+8];
	wire [DW-1:0] s_din = sync2[DW+7:8];
	wire s_cen_n = sync2[7];
	wire s_adv = sync2[6];
	wire s_rw_n = sync2[5];
	wire s_cs_a_n = sync2[4];
	wire s_cs_b_n = sync2[3];
	wire s_cs_h = sync2[2];
	wire s_order = sync2[1];
	wire s_order_drv = sync2[0];
	wire s_oe_n = oe_s2; // synced like every pin, so it masks the drivers late

	// stored address / burst state
	logic [ADDR_W-1:0] base;
	logic [`BURST_BITS-1:0] step;
	logic burst_dir_rd;
	logic burst_live;
	logic order_inter;
	// data phase pipeline
	sram_port_pkg::phase_t phase;
	logic [ADDR_W-1:0] ph_addr;
	logic [LANES-1:0] ph_lane_n;
	logic [DW-1:0] rd_word;
	logic driving;

	// decoding of the sampled control
	wire live = !s_cen_n;
	wire selected = !s_cs_a_n && !s_cs_b_n && s_cs_h;
	wire is_load = !s_adv;
	wire do_load = is_load && selected;
	wire do_desel = is_load && !selected;
	wire do_adv = s_adv && burst_live;
	wire inter_now = !s_order_drv || s_order;
	wire [`BURST_BITS-1:0] next_step = step + 2'h1;
	wire [`BURST_BITS-1:0] lin_low = base[`BURST_BITS-1:0] + next_step;
	wire [`BURST_BITS-1:0] int_low = base[`BURST_BITS-1:0] ^ next_step;
	wire [`BURST_BITS-1:0] adv_low = order_inter ? int_low : lin_low;
	wire [ADDR_W-1:0] adv_addr = {base[ADDR_W-1:`BURST_BITS], adv_low};
	wire next_rd = do_load ? s_rw_n : burst_dir_rd;
	wire [ADDR_W-1:0] next_addr = do_load ? s_addr : adv_addr;
	wire next_act = do_load || do_adv;
	sram_port_pkg::phase_t next_phase;
	assign next_phase = !next_act ? sram_port_pkg::PH_IDLE :
		(next_rd ? sram_port_pkg::PH_READ : sram_port_pkg::PH_WRITE);

	// burst state: load restarts, deselect stops, advance steps
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			step <= `STEP_RESET;
			burst_live <= 1'b0;
			burst_dir_rd <= 1'b1;
			order_inter <= 1'b1;
			base <= '0;
		end else if (live) begin
			if (do_load) begin
				base <= s_addr;
				step <= `STEP_RESET;
				burst_dir_rd <= s_rw_n;
				order_inter <= inter_now;
				burst_live <= 1'b1;
			end else if (do_desel) begin
				burst_live <= 1'b0;
			end else if (do_adv) begin
				step <= next_step;
			end
		end
	end

	// address/control stage feeding next cycle's data phase
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			phase <= sram_port_pkg::PH_IDLE;
			ph_addr <= '0;
			ph_lane_n <= '1;
		end else if (live) begin
			phase <= next_phase;
			ph_addr <= next_addr;
			ph_lane_n <= s_lane_n;
		end
	end

	// data phase: write lands whatever the select state is now; one array per lane
	wire [DW-1:0] rd_next;
	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			logic [LANE_W-1:0] lane_mem [0:DEPTH-1];
			wire lane_we = live && phase == sram_port_pkg::PH_WRITE && !ph_lane_n[g];
			// a read of the word written at this edge takes the incoming lane, not the stale one
			wire lane_fwd = lane_we && ph_addr == next_addr;
			assign rd_next[g*LANE_W +: LANE_W] = lane_fwd ? s_din[g*LANE_W +: LANE_W] :
				lane_mem[next_addr];
			always_ff @(posedge CLK_SYS) begin
				if (!RST && lane_we) begin
					lane_mem[ph_addr] <= s_din[g*LANE_W +: LANE_W];
				end
			end
		end
	endgenerate

	// read data registered in its data phase; drivers off otherwise
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			driving <= 1'b0;
			rd_word <= '0;
		end else if (live) begin
			driving <= (next_phase == sram_port_pkg::PH_READ);
			rd_word <= rd_next;
		end
	end

	// output enable only masks the drivers, registered as the outputs must be
	always_ff @(posedge CLK_SYS) begin
		if (RST) begin
			DATA_OUT <= '0;
			DATA_OE <= '0;
		end else begin
			DATA_OUT <= rd_word;
			DATA_OE <= {DW{driving && !s_oe_n}};
		end
	end

	// assertions
	a_freeze_step: assert property (@(posedge CLK_SYS) disable iff (RST)
		!live |=> $stable(step) && $stable(phase))
		else $error("burst state moved while clock enable high");
	a_desel_stops: assert property (@(posedge CLK_SYS) disable iff (RST)
		live && do_desel |=> !burst_live && phase == sram_port_pkg::PH_IDLE)
		else $error("deselect did not stop the burst");
	a_load_restart: assert property (@(posedge CLK_SYS) disable iff (RST)
		live && do_load |=> step == `STEP_RESET && base == $past(s_addr))
		else $error("load did not restart the burst");
	a_dir_held: assert property (@(posedge CLK_SYS) disable iff (RST)
		live && do_adv |=> phase == ($past(burst_dir_rd) ? sram_port_pkg::PH_READ :
		sram_port_pkg::PH_WRITE))
		else $error("burst direction not kept during advance");
	a_write_start: assert property (@(posedge CLK_SYS) disable iff (RST)
		live && do_load && !s_rw_n |=> phase == sram_port_pkg::PH_WRITE)
		else $error("write not started on load with read-write low");
	a_upper_fixed: assert property (@(posedge CLK_SYS) disable iff (RST)
		live && do_adv |=> ph_addr[ADDR_W-1:2] == base[ADDR_W-1:2])
		else $error("upper address bits moved in burst");
	a_idle_quiet: assert property (@(posedge CLK_SYS) disable iff (RST)
		live && s_adv && !burst_live |=> !driving ##1 DATA_OE == '0)
		else $error("bus driven with no burst running");
	a_read_drive: assert property (@(posedge CLK_SYS) disable iff (RST)
		live && do_load && s_rw_n |=> driving)
		else $error("read load did not drive next cycle");
	a_oe_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
		$past(s_oe_n) |-> DATA_OE == '0)
		else $error("drivers on with output enable high");
	c_masked: cover property (@(posedge CLK_SYS) disable iff (RST) driving && s_oe_n);
	c_burst: cover property (@(posedge CLK_SYS) disable iff (RST)
		live && do_load ##1 (live && do_adv) [*3]);
	c_desel: cover property (@(posedge CLK_SYS) disable iff (RST)
		live && do_load ##1 live && do_desel);
	c_stall: cover property (@(posedge CLK_SYS) disable iff (RST) live && do_load ##1 !live);
endmodule

// ### rtl/sram_port_defs.svh
/*
 * Shared constants for the pipelined burst SRAM port: geometry and reset values.
 * Assumes inclusion by the port module and any bench that needs the same figures.
 */
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH
`define ADDR_BITS 17
`define LANES 4
`define LANE_BITS 9
`define BURST_BITS 2
`define STEP_RESET 2'h0
`endif

// ### rtl/sram_port_pkg.sv
/*
 * Types for the pipelined burst SRAM port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sram_port_pkg;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_READ = 2'b01,
		PH_WRITE = 2'b10
	} phase_t;
endpackage

// ### testbench/sram_ctl_model.sv
/* controller model: drives write data one cycle after its beat.
   assumes the bench raises beat with the address cycle, on falling edges */
`timescale 1ns/100ps
`include "sram_port_defs.svh"
module sram_ctl_model (
	input wire logic clk,
	input wire logic beat,
	input wire logic [`LANES*`LANE_BITS-1:0] wdata,
	output logic [`LANES*`LANE_BITS-1:0] data_in
);
	logic pend = 1'h0;
	logic [`LANES*`LANE_BITS-1:0] held = '0;
	initial data_in = '0;
	// take beat and word on the rising edge, where the bench has left them settled
	always @(posedge clk) begin
		pend <= beat;
		held <= wdata;
	end
	// word goes out one cycle after its beat; a released bus toggles so stale data never passes
	always @(negedge clk) begin
		data_in <= pend ? held : ~data_in;
	end
endmodule

// ### testbench/burst_sram_port_tb.sv
/* bench for the burst port: writes, bursts in both orders, lanes, deselects.
   also stalls and output-enable masking.
   assumes the two-flop input sync of the port, so answers land four steps on */
`timescale 1ns/100ps
`include "sram_port_defs.svh"
module burst_sram_port_tb;
	localparam int DW = `LANES*`LANE_BITS;
	localparam logic [16:0] BASE = 17'h1A5F0;
	localparam logic [DW-1:0] HI_LANES = 36'hFFFFFFE00; // lanes the lane test masks off
	// advance with no burst running is the idle pattern
	logic clk = 1'h0, rst = 1'h1, adv = 1'h1, rw = 1'h1, bos = 1'h1, bod = 1'h1;
	logic beat = 1'h0, bw = 1'h0, mix = 1'h0;
	logic clock_enable_n = 1'h0, oe = 1'h0, cen_nx = 1'h0, oe_nx = 1'h0;
	logic [2:0] sel = 3'h1; // low a, low b, high
	logic [16:0] addr = '0;
	logic [3:0] ln = '1;
	logic [DW-1:0] wd = '0, din, dout, doe, cap[0:255], oec[0:255];
	int n = 0, k, err_count = 0, comparisons = 0;
	burst_sram_port burst_sram_port_inst (.CLK_SYS(clk), .RST(rst), .CLOCK_ENABLE_N(clock_enable_n),
		.ADVANCE_OR_LOAD(adv), .READ_WRITE_N(rw), .SELECT_LOW_A_N(sel[2]),
		.SELECT_LOW_B_N(sel[1]), .SELECT_HIGH(sel[0]), .BURST_ORDER_SEL(bos),
		.BURST_ORDER_DRIVEN(bod), .OUTPUT_ENABLE_N(oe), .ADDR(addr),
		.BYTE_LANE_WRITE_N(ln), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(doe));
	sram_ctl_model sram_ctl_model_inst (.clk(clk), .beat(beat), .wdata(wd), .data_in(din));
	initial forever #10 clk = ~clk;
	function automatic logic [DW-1:0] wv(input int i);
		logic [DW-1:0] w;
		w = 36'h35A69C300 + DW'(i * 7);
		return mix ? {w[DW-1:9], ~w[8:0]} : w;
	endfunction
	// one address cycle; the bus as seen just before it is logged
	task automatic step(input logic a, r, input logic [2:0] s, input logic [16:0] ad,
		input logic [3:0] l, input logic [DW-1:0] d);
		@(negedge clk);
		cap[n] = dout;
		oec[n] = doe;
		n++;
		if (!a) bw = (s == 3'h1) && !r;
		{adv, rw, sel, addr, ln, wd, beat} = {a, r, s, ad, l, d, bw};
		clock_enable_n = cen_nx;
		oe = oe_nx;
	endtask
	task automatic check(input logic [DW-1:0] g, e);
		comparisons++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic idle(input int c);
		repeat (c) step(1'h1, 1'h1, 3'h1, '0, '1, '0);
	endtask
	task automatic t_write;
		k = n;
		for (int i = 0; i < 4; i++) step(1'h0, 1'h0, 3'h1, BASE + 17'(i), 4'h0, wv(i));
		step(1'h0, 1'h1, 3'h0, BASE, '1, '0);
		idle(6);
		for (int i = 4; i < 11; i++) check(oec[k+i], '0);
		$display("write test done");
	endtask
	// the last beat lands in the deselect slot, proving it still completes
	task automatic t_burst(input logic o, dr, input int st);
		k = n;
		bos = o;
		bod = dr;
		step(1'h0, 1'h1, 3'h1, BASE + 17'(st), '1, '0);
		repeat (3) step(1'h1, 1'h0, 3'h1, '0, 4'h0, '0);
		step(1'h0, 1'h1, 3'h0, '0, '1, '0);
		idle(6);
		for (int j = 0; j < 4; j++) begin
			check(cap[k+4+j], wv((o || !dr) ? st ^ j : (st + j) % 4));
			check(oec[k+4+j], '1);
		end
		check(oec[k+8], '0);
		check(oec[k+9], '0);
		$display("burst test done");
	endtask
	task automatic t_lane;
		bos = 1'h0;
		mix = 1'h1;
		// masked lanes carry inverted data, so a stray write would show on the read back
		step(1'h0, 1'h0, 3'h1, BASE, 4'hE, wv(0) ^ HI_LANES);
		for (int j = 1; j < 4; j++) step(1'h1, 1'h1, 3'h1, '0, 4'hE, wv(j) ^ HI_LANES);
		step(1'h0, 1'h1, 3'h0, '0, '1, '0);
		idle(4);
		t_burst(1'h0, 1'h1, 0);
		$display("lane test done");
	endtask
	task automatic t_desel;
		for (int i = 0; i < 3; i++) begin
			k = n;
			step(1'h0, 1'h1, (i == 0) ? 3'h0 : (i == 1) ? 3'h5 : 3'h3, BASE, '1, '0);
			idle(6);
			check(oec[k+4], '0);
			check(oec[k+5], '0);
		end
		$display("deselect test done");
	endtask
	// stall two edges inside a read burst, then mask one beat with output enable
	task automatic t_hold;
		k = n;
		step(1'h0, 1'h1, 3'h1, BASE, '1, '0);
		cen_nx = 1'h1;
		// a deselect load while frozen must be ignored
		repeat (2) step(1'h0, 1'h0, 3'h0, '0, '1, '0);
		cen_nx = 1'h0;
		step(1'h1, 1'h1, 3'h1, '0, '1, '0);
		oe_nx = 1'h1;
		step(1'h1, 1'h1, 3'h1, '0, '1, '0);
		oe_nx = 1'h0;
		step(1'h1, 1'h1, 3'h1, '0, '1, '0);
		step(1'h0, 1'h1, 3'h0, '0, '1, '0);
		idle(4);
		for (int j = 0; j < 6; j++) begin
			check(cap[k+4+j], wv((j < 3) ? 0 : j - 2));
			check(oec[k+4+j], {DW{j != 3}});
		end
		check(oec[k+10], '0);
		$display("hold test done");
	endtask
	task automatic end_of_test;
		$display("%0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// the whole run needs about 120 cycles
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		end_of_test;
	end
	initial begin
		repeat (20) @(posedge clk);
		@(negedge clk) rst = 1'h0;
		repeat (3) @(negedge clk);
		check(doe, '0);
		$display("reset test done");
		t_write;
		t_burst(1'h0, 1'h1, 1);
		t_burst(1'h1, 1'h1, 2);
		t_burst(1'h0, 1'h0, 3);
		t_lane;
		t_hold;
		t_desel;
		end_of_test;
	end
endmodule
